/* logic/fcs_consts.svh */
// Purpose: constants for the flash command sequencer
// Assumes: 16-bit CPU address, 8-bit data, 40 MHz clock
// Notes:   timing counts derive from printed times and the clock rate
`ifndef FCS_CONSTS_SVH
`define FCS_CONSTS_SVH
`define FCS_CLK_MHZ        40
`define FCS_PROG_US        40
`define FCS_PROG_CYC       (`FCS_PROG_US * `FCS_CLK_MHZ)
`define FCS_ERASE_MS       30
`define FCS_ERASE_CYC      (`FCS_ERASE_MS * 1000 * `FCS_CLK_MHZ)
`define FCS_LOW_MASK       16'h0FFF
`define FCS_ADDR_555       16'h0555
`define FCS_ADDR_AAA       16'h0AAA
`define FCS_ADDR_PROT      16'hFF7F
`define FCS_ADDR_VENDOR    16'hF000
`define FCS_ADDR_MACRO     16'hF001
`define FCS_ADDR_SIZE      16'hF002
`define FCS_D_AA           8'hAA
`define FCS_D_55           8'h55
`define FCS_D_PROG         8'hA0
`define FCS_D_ERASE        8'h80
`define FCS_D_SECT         8'h30
`define FCS_D_CHIP         8'h10
`define FCS_D_IDIN         8'h90
`define FCS_D_IDOUT        8'hF0
`define FCS_D_PROT         8'hA5
`define FCS_D_PROT4        8'h00
`define FCS_D_FF           8'hFF
`define FCS_PROT_ON        8'h00
`define FCS_CMD_EN         4'h3
`define FCS_TOGGLE_BIT     6
`endif

/* logic/fcs_pkg.sv */
// Purpose: types for the flash command sequencer
// Assumes: nothing beyond the constants header
// Notes:   mode encoding for the memory access mode input
package fcs_pkg;
  typedef enum logic [1:0] {
    FCS_MODE_MCU,
    FCS_MODE_SERIAL,
    FCS_MODE_PARALLEL
  } fcs_mode_t;
  typedef enum {
    FCS_IDLE, FCS_C1, FCS_C2, FCS_PROG4, FCS_ER3, FCS_ER4, FCS_ER5, FCS_PROT4, FCS_BUSY
  } fcs_state_t;
endpackage

/* logic/fcs_sequencer.sv */
// Purpose: decodes flash command sequences and runs program/erase/protect
// Assumes: one-cycle bus strobes from the cpu core on REF_CLK
// Notes:   array of SIZE bytes mapped at the top of the 64 kbyte space
`timescale 1ns/10ps
`include "fcs_consts.svh"

//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - command addresses compare low 12 bits; target and protect address full, sector upper four bits
// - upper four address bits select the flash area addressed
// - byte program is AA/555, 55/AAA, A0/555, then data to target
// - one byte program completes within 40 us
// - no new sequence accepted while an operation runs
// - repeated reads during an operation invert data bit 6
// - sector erase is six cycles ending with 30H to the sector
// - sector erase finishes within 30 ms
// - sector erase ignored in parallel programming mode
// - chip erase ends with 10H to 555; all bytes read FFH after
// - chip erase completes in about 30 ms
// - product id entry AA, 55, 90 enters identification mode
// - id mode reads vendor, macro, size codes and protect status
// - size code encodes array size, 03H for 16 kbytes
// - protect location reads FFH unprotected, otherwise protected
// - id mode left by single F0H or three-cycle F0H sequence
// - read protect is AA, 55, A5 to 555, then 00H to FF7F
// - protection blocks parallel reads and serial write and loader commands
// - only chip erase clears read protection; RST also clears it here
// - read protect completes within 40 us with bit 6 toggling
// - sequences act only when command enable field holds 0011B
// - first read after program, chip erase or protect returns bit 6 one
module fcs_sequencer
#(
  parameter int SIZE      = 16384,
  parameter int PROG_CYC  = `FCS_PROG_CYC,
  parameter int ERASE_CYC = `FCS_ERASE_CYC,
  parameter logic [7:0] VENDOR_CODE = 8'h5A, // arbitrary value
  parameter logic [7:0] MACRO_CODE  = 8'h3C, // arbitrary value
  parameter logic [7:0] SIZE_CODE   = 8'h03
) (
  input  wire logic             REF_CLK,
  input  wire logic             RST,
  input  wire logic [3:0]       CMD_ENABLE_FIELD,
  input  wire fcs_pkg::fcs_mode_t MODE,
  input  wire logic             WR_STB,
  input  wire logic             RD_STB,
  input  wire logic [15:0]      ADDR,
  input  wire logic [7:0]       WDATA,
  output logic [7:0]            RDATA,
  output logic                  RDATA_VALID,
  output logic                  BUSY,
  output logic                  ID_MODE,
  output logic                  READ_PROTECTED,
  output logic                  SERIAL_CMD_BLOCK
);
  import fcs_pkg::*;

  localparam int AW = $clog2(SIZE);
  localparam logic [15:0] BASE = 16'(17'h10000 - SIZE);

  logic [7:0]  mem [SIZE];
  fcs_state_t  st_r;
  logic [31:0] cnt_r;
  logic        id_r;
  logic        prot_r;
  logic        tog_r;
  logic [1:0]  op_r; // 0 prog, 1 sector, 2 chip, 3 protect
  logic [15:0] op_addr_r;
  logic [7:0]  op_data_r;
  logic [7:0]  rdata_r;
  logic        rvalid_r;

  //////////////////////////////////////////////////////////////////////////////
  // command address match
  logic [11:0] low;
  logic        a555, aaaa, en, in_arr, sect_ok;
  logic [AW-1:0] idx;
  assign low  = ADDR[11:0];
  assign a555 = low == `FCS_ADDR_555;
  assign aaaa = low == `FCS_ADDR_AAA;
  assign en   = CMD_ENABLE_FIELD == `FCS_CMD_EN;
  assign in_arr = ADDR >= BASE;
  assign idx  = AW'(ADDR - BASE);
  // sector select uses the upper nibble; only nibbles inside the array count
  assign sect_ok = {ADDR[15:12], 12'h000} >= BASE;

  //////////////////////////////////////////////////////////////////////////////
  // sequence decoder and operation timer
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      st_r      <= FCS_IDLE;
      cnt_r     <= 32'h0000_0000;
      id_r      <= 1'b0;
      op_r      <= 2'h0;
      op_addr_r <= 16'h0000;
      op_data_r <= 8'h00;
    end else if (st_r == FCS_BUSY) begin
      // writes are ignored until the operation is done
      if (cnt_r == 32'h0000_0001) begin
        st_r <= FCS_IDLE;
      end
      cnt_r <= cnt_r - 32'h0000_0001;
    end else if (WR_STB && en) begin
      st_r <= FCS_IDLE;
      case (st_r)
        FCS_IDLE: begin
          if (WDATA == `FCS_D_AA && a555) begin
            st_r <= FCS_C1;
          end else if (WDATA == `FCS_D_IDOUT && id_r) begin
            id_r <= 1'b0;
          end
        end
        FCS_C1: begin
          if (WDATA == `FCS_D_55 && aaaa) begin
            st_r <= FCS_C2;
          end
        end
        FCS_C2: begin
          if (a555) begin
            case (WDATA)
              `FCS_D_PROG:  st_r <= FCS_PROG4;
              `FCS_D_ERASE: st_r <= FCS_ER3;
              `FCS_D_IDIN:  id_r <= 1'b1;
              `FCS_D_IDOUT: id_r <= 1'b0;
              `FCS_D_PROT:  st_r <= FCS_PROT4;
              default:      st_r <= FCS_IDLE;
            endcase
          end
        end
        FCS_PROG4: begin
          if (in_arr) begin
            op_r      <= 2'h0;
            op_addr_r <= ADDR;
            op_data_r <= WDATA;
            cnt_r     <= PROG_CYC;
            st_r      <= FCS_BUSY;
          end
        end
        FCS_ER3: begin
          if (WDATA == `FCS_D_AA && a555) begin
            st_r <= FCS_ER4;
          end
        end
        FCS_ER4: begin
          if (WDATA == `FCS_D_55 && aaaa) begin
            st_r <= FCS_ER5;
          end
        end
        FCS_ER5: begin
          if (WDATA == `FCS_D_SECT && MODE != FCS_MODE_PARALLEL && sect_ok) begin
            op_r      <= 2'h1;
            op_addr_r <= ADDR;
            cnt_r     <= ERASE_CYC;
            st_r      <= FCS_BUSY;
          end else if (WDATA == `FCS_D_CHIP && a555) begin
            op_r  <= 2'h2;
            cnt_r <= ERASE_CYC;
            st_r  <= FCS_BUSY;
          end
        end
        FCS_PROT4: begin
          if (WDATA == `FCS_D_PROT4 && ADDR == `FCS_ADDR_PROT) begin
            op_r  <= 2'h3;
            cnt_r <= PROG_CYC;
            st_r  <= FCS_BUSY;
          end
        end
        default: st_r <= FCS_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // array update at the end of an operation
  logic done;
  assign done = st_r == FCS_BUSY && cnt_r == 32'h0000_0001;
  always_ff @(posedge REF_CLK) begin
    if (done) begin
      for (int i = 0; i < SIZE; i++) begin
        // programming can only clear bits; overwriting needs an erase first
        if (op_r == 2'h0 && AW'(i) == AW'(op_addr_r - BASE)) begin
          mem[i] <= mem[i] & op_data_r;
        end else if (op_r == 2'h1 && 4'((BASE + 16'(i)) >> 12) == op_addr_r[15:12]) begin
          mem[i] <= `FCS_D_FF;
        end else if (op_r == 2'h2) begin
          mem[i] <= `FCS_D_FF;
        end
      end
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      prot_r <= 1'b0;
    end else if (done && op_r == 2'h3) begin
      prot_r <= 1'b1;
    end else if (done && op_r == 2'h2) begin
      prot_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read path
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      tog_r    <= 1'b1;
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= RD_STB;
      if (st_r != FCS_BUSY) begin
        tog_r <= 1'b1;
      end
      if (RD_STB) begin
        if (st_r == FCS_BUSY) begin
          rdata_r <= 8'h00;
          rdata_r[`FCS_TOGGLE_BIT] <= tog_r;
          tog_r   <= ~tog_r;
        end else if (id_r && ADDR == `FCS_ADDR_VENDOR) begin
          rdata_r <= VENDOR_CODE;
        end else if (id_r && ADDR == `FCS_ADDR_MACRO) begin
          rdata_r <= MACRO_CODE;
        end else if (id_r && ADDR == `FCS_ADDR_SIZE) begin
          rdata_r <= SIZE_CODE;
        end else if (id_r && ADDR == `FCS_ADDR_PROT) begin
          rdata_r <= prot_r ? `FCS_PROT_ON : `FCS_D_FF;
        end else if (!in_arr || (prot_r && MODE == FCS_MODE_PARALLEL)) begin
          rdata_r <= 8'h00;
        end else begin
          rdata_r <= mem[idx];
        end
      end
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      RDATA            <= 8'h00;
      RDATA_VALID      <= 1'b0;
      BUSY             <= 1'b0;
      ID_MODE          <= 1'b0;
      READ_PROTECTED   <= 1'b0;
      SERIAL_CMD_BLOCK <= 1'b0;
    end else begin
      RDATA            <= rdata_r;
      RDATA_VALID      <= rvalid_r;
      BUSY             <= st_r == FCS_BUSY;
      ID_MODE          <= id_r;
      READ_PROTECTED   <= prot_r;
      SERIAL_CMD_BLOCK <= prot_r && MODE == FCS_MODE_SERIAL;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  // remembers the bit shown by the previous read of the running operation, so the
  // toggle checks hold for reads spaced any distance apart, not only back to back
  logic busy_rd_seen_r;
  logic busy_rd_bit_r;
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      busy_rd_seen_r <= 1'b0;
      busy_rd_bit_r  <= 1'b0;
    end else if (st_r != FCS_BUSY) begin
      busy_rd_seen_r <= 1'b0;
    end else if (RD_STB) begin
      busy_rd_seen_r <= 1'b1;
      busy_rd_bit_r  <= rdata_r[`FCS_TOGGLE_BIT];
    end
  end

  busy_holds_off_a: assert property (@(posedge REF_CLK) disable iff (RST)
    st_r == FCS_BUSY && cnt_r > 32'h1 |=> st_r == FCS_BUSY)
    else $error("operation ended early");
  toggle_flips_a: assert property (@(posedge REF_CLK) disable iff (RST)
    RD_STB && st_r == FCS_BUSY && busy_rd_seen_r |=> rdata_r[6] != busy_rd_bit_r)
    else $error("bit 6 did not toggle");
  first_read_one_a: assert property (@(posedge REF_CLK) disable iff (RST)
    RD_STB && st_r == FCS_BUSY && !busy_rd_seen_r |=> rdata_r[6])
    else $error("first busy read not one");
  enable_gate_a: assert property (@(posedge REF_CLK) disable iff (RST)
    st_r == FCS_IDLE && !en |=> st_r == FCS_IDLE)
    else $error("sequence advanced while disabled");
  parallel_sector_a: assert property (@(posedge REF_CLK) disable iff (RST)
    st_r == FCS_ER5 && WR_STB && en && MODE == FCS_MODE_PARALLEL && WDATA == `FCS_D_SECT
    |=> st_r == FCS_IDLE)
    else $error("sector erase in parallel mode");
  prot_clear_a: assert property (@(posedge REF_CLK) disable iff (RST)
    $fell(prot_r) |-> $past(done) && $past(op_r) == 2'h2)
    else $error("protection cleared without chip erase");
  prot_status_a: assert property (@(posedge REF_CLK) disable iff (RST)
    RD_STB && id_r && st_r != FCS_BUSY && ADDR == `FCS_ADDR_PROT
    |=> rdata_r == (prot_r ? 8'h00 : 8'hFF))
    else $error("bad protect status read");
  mismatch_abort_a: assert property (@(posedge REF_CLK) disable iff (RST)
    st_r == FCS_C1 && WR_STB && en && !(aaaa && WDATA == 8'h55) |=> st_r == FCS_IDLE)
    else $error("mismatch did not abandon sequence");
  busy_flag_a: assert property (@(posedge REF_CLK) disable iff (RST)
    st_r == FCS_BUSY |=> BUSY)
    else $error("busy output not raised");
  busy_ignores_a: assert property (@(posedge REF_CLK) disable iff (RST)
    st_r == FCS_BUSY |=> $stable(id_r) && $stable(op_addr_r) && $stable(op_r))
    else $error("write taken during operation");
  prog_start_a: assert property (@(posedge REF_CLK) disable iff (RST)
    st_r == FCS_PROG4 && WR_STB && en && in_arr |=> st_r == FCS_BUSY && cnt_r == PROG_CYC)
    else $error("byte program did not start");
  sector_start_a: assert property (@(posedge REF_CLK) disable iff (RST)
    st_r == FCS_ER5 && WR_STB && en && WDATA == 8'h30 && MODE != FCS_MODE_PARALLEL
    && sect_ok |=> st_r == FCS_BUSY && op_r == 2'h1 && cnt_r == ERASE_CYC)
    else $error("sector erase did not start");
  chip_start_a: assert property (@(posedge REF_CLK) disable iff (RST)
    st_r == FCS_ER5 && WR_STB && en && WDATA == 8'h10 && a555
    |=> st_r == FCS_BUSY && op_r == 2'h2 && cnt_r == ERASE_CYC)
    else $error("chip erase did not start");
  protect_start_a: assert property (@(posedge REF_CLK) disable iff (RST)
    st_r == FCS_PROT4 && WR_STB && en && WDATA == 8'h00 && ADDR == 16'hFF7F
    |=> st_r == FCS_BUSY && op_r == 2'h3 && cnt_r == PROG_CYC)
    else $error("read protect did not start");
  id_entry_a: assert property (@(posedge REF_CLK) disable iff (RST)
    st_r == FCS_C2 && WR_STB && en && a555 && WDATA == 8'h90 |=> id_r)
    else $error("id mode not entered");
  id_exit_a: assert property (@(posedge REF_CLK) disable iff (RST)
    st_r == FCS_IDLE && WR_STB && en && WDATA == 8'hF0 |=> !id_r)
    else $error("id mode not left");
  id_flag_a: assert property (@(posedge REF_CLK) disable iff (RST)
    id_r |=> ID_MODE)
    else $error("id mode output not raised");
  vendor_read_a: assert property (@(posedge REF_CLK) disable iff (RST)
    RD_STB && id_r && st_r != FCS_BUSY && ADDR == 16'hF000 |=> rdata_r == VENDOR_CODE)
    else $error("bad vendor code read");
  size_read_a: assert property (@(posedge REF_CLK) disable iff (RST)
    RD_STB && id_r && st_r != FCS_BUSY && ADDR == 16'hF002 |=> rdata_r == SIZE_CODE)
    else $error("bad size code read");
  protect_set_a: assert property (@(posedge REF_CLK) disable iff (RST)
    done && op_r == 2'h3 |=> prot_r)
    else $error("protection not set");
  unprotect_a: assert property (@(posedge REF_CLK) disable iff (RST)
    done && op_r == 2'h2 |=> !prot_r)
    else $error("chip erase left protection set");
  parallel_block_a: assert property (@(posedge REF_CLK) disable iff (RST)
    RD_STB && st_r != FCS_BUSY && !id_r && prot_r && MODE == FCS_MODE_PARALLEL
    |=> rdata_r == 8'h00)
    else $error("protected parallel read not blocked");
  serial_block_a: assert property (@(posedge REF_CLK) disable iff (RST)
    prot_r && MODE == FCS_MODE_SERIAL |=> SERIAL_CMD_BLOCK)
    else $error("serial commands not blocked");
endmodule

/* verif/fcs_cpu_model.sv */
// Purpose: cpu core bus model that issues write and read cycles to the sequencer
// Assumes: the sequencer samples strobes on the rising edge of ref_clk
// Notes:   released address and data lines carry the inverse of the last value
`timescale 1ns/10ps
module fcs_cpu_model (
  input  wire logic        ref_clk,
  output logic             wr_stb,
  output logic             rd_stb,
  output logic [15:0]      addr,
  output logic [7:0]       wdata,
  input  wire logic [7:0]  rdata,
  input  wire logic        rdata_valid
);
  initial begin
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    addr   = 16'h0000;
    wdata  = 8'h00;
  end
  //////////////////////////////////////////////////////////////////////////////
  // strobe spans exactly one rising edge, so one write is never taken twice
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    wr_stb = 1'b1;
    addr   = a;
    wdata  = d;
    @(negedge ref_clk);
    wr_stb = 1'b0;
    addr   = ~a;
    wdata  = ~d;
  endtask
  // ok stays low when no answer comes within four cycles
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic ok);
    @(negedge ref_clk);
    rd_stb = 1'b1;
    addr   = a;
    @(negedge ref_clk);
    rd_stb = 1'b0;
    addr   = ~a;
    ok     = 1'b0;
    d      = 8'h00;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(negedge ref_clk);
      if (rdata_valid === 1'b1) begin
        ok = 1'b1;
        d  = rdata;
      end
    end
  endtask
endmodule

/* verif/flash_command_sequencer_tb.sv */
// Purpose: self-checking bench for the flash command sequencer
// Assumes: short operation counts so a full run stays small
// Notes:   array contents are modelled in an associative array, FFH when absent
`timescale 1ns/10ps
module flash_command_sequencer_tb;
  import fcs_pkg::*;
  localparam int         PROG  = 20;
  localparam int         ERASE = 50;
  localparam logic [7:0] VEND  = 8'h5A; // arbitrary value
  localparam logic [7:0] MACR  = 8'h3C; // arbitrary value
  logic       ref_clk, rst, wr_stb, rd_stb, rvalid, busy, id_mode, rprot, sblk;
  logic [3:0] cmd_en;
  fcs_mode_t  mode;
  logic [15:0] addr, a1;
  logic [7:0] wdata, rdata, r, d1;
  logic [7:0] mem [int];
  int         error_cnt, num_checks;
  int unsigned seed;
  fcs_sequencer #(.PROG_CYC(PROG), .ERASE_CYC(ERASE), .VENDOR_CODE(VEND),
                  .MACRO_CODE(MACR)) u_fcs_sequencer (
    .REF_CLK(ref_clk), .RST(rst), .CMD_ENABLE_FIELD(cmd_en), .MODE(mode),
    .WR_STB(wr_stb), .RD_STB(rd_stb), .ADDR(addr), .WDATA(wdata), .RDATA(rdata),
    .RDATA_VALID(rvalid), .BUSY(busy), .ID_MODE(id_mode), .READ_PROTECTED(rprot),
    .SERIAL_CMD_BLOCK(sblk));
  fcs_cpu_model u_fcs_cpu_model (.ref_clk(ref_clk), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .addr(addr), .wdata(wdata), .rdata(rdata), .rdata_valid(rvalid));
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    end_sim();
  end
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  function automatic logic [7:0] expv(input logic [15:0] a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    logic ok;
    u_fcs_cpu_model.rd(a, d, ok);
    if (ok !== 1'b1) begin
      chk(8'h01, 8'h00, "read not answered");
      end_sim();
    end
  endtask
  // random upper nibble: command addresses match on the low twelve bits only
  task automatic seq(input logic [7:0] d3);
    u_fcs_cpu_model.wr({4'($urandom), 12'h555}, 8'hAA);
    u_fcs_cpu_model.wr({4'($urandom), 12'hAAA}, 8'h55);
    u_fcs_cpu_model.wr({4'($urandom), 12'h555}, d3);
  endtask
  // polls until two reads match; busy reads show only the toggling bit
  task automatic poll(input logic [15:0] a);
    logic [7:0] prev, cur;
    logic       tog;
    tog = 1'b1;
    @(negedge ref_clk);
    rd(a, prev);
    chk(prev, 8'h40, "first read during operation");
    for (int i = 0; i < 40; i++) begin
      rd(a, cur);
      if (cur === prev) begin
        chk(cur, expv(a), "data after operation");
        return;
      end
      tog = ~tog;
      if (cur !== expv(a)) chk(cur, {1'b0, tog, 6'b0}, "toggle bit");
      prev = cur;
    end
    chk(8'h01, 8'h00, "operation never finished");
    end_sim();
  endtask
  task automatic erase(input logic [7:0] d6, input logic [15:0] a6);
    seq(8'h80);
    u_fcs_cpu_model.wr({4'($urandom), 12'h555}, 8'hAA);
    u_fcs_cpu_model.wr({4'($urandom), 12'hAAA}, 8'h55);
    u_fcs_cpu_model.wr(a6, d6);
  endtask
  task automatic prog(input logic [15:0] a, input logic [7:0] d);
    seq(8'hA0);
    u_fcs_cpu_model.wr(a, d);
    mem[a] = expv(a) & d;
    poll(a);
  endtask
  task automatic idle_chk(input logic [15:0] a, input string what);
    repeat (4) @(negedge ref_clk);
    chk({7'b0, busy}, 8'h00, what);
    rd(a, r);
    chk(r, expv(a), what);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    error_cnt = 0;
    num_checks = 0;
    rst = 1'b1;
    cmd_en = 4'hC;
    mode = FCS_MODE_MCU;
    seed = $urandom(58);
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    chk({4'b0, busy, id_mode, rprot, sblk}, 8'h00, "outputs after reset");
    cmd_en = 4'h3;
    a1 = {4'hC, 12'($urandom)};
    erase(8'h10, {4'($urandom), 12'h555});
    poll(a1);
    for (int i = 0; i < 4; i++) begin
      rd({2'b11, 14'($urandom)}, r);
      chk(r, 8'hFF, "erased byte");
    end
    // a second program sent while the first is still running must be dropped
    d1 = 8'($urandom) | 8'h01;
    seq(8'hA0);
    u_fcs_cpu_model.wr(a1, d1);
    mem[a1] = expv(a1) & d1;
    seq(8'hA0);
    u_fcs_cpu_model.wr(a1 ^ 16'h0010, 8'($urandom) & 8'hFE);
    chk({7'b0, busy}, 8'h01, "busy during program");
    poll(a1);
    rd(a1 ^ 16'h0010, r);
    chk(r, expv(a1 ^ 16'h0010), "program refused while busy");
    cmd_en = 4'hC;
    seq(8'hA0);
    u_fcs_cpu_model.wr(a1 ^ 16'h0020, 8'h01);
    idle_chk(a1 ^ 16'h0020, "disabled program");
    cmd_en = 4'h3;
    seq(8'h77);
    u_fcs_cpu_model.wr(a1 ^ 16'h0040, 8'h01);
    idle_chk(a1 ^ 16'h0040, "abandoned sequence");
    // a wrong second cycle must not let the rest of a program through
    u_fcs_cpu_model.wr(16'h0555, 8'hAA);
    u_fcs_cpu_model.wr(16'h0AAA, 8'h33);
    u_fcs_cpu_model.wr(16'h0AAA, 8'h55);
    u_fcs_cpu_model.wr(16'h0555, 8'hA0);
    u_fcs_cpu_model.wr(a1 ^ 16'h0040, 8'h01);
    idle_chk(a1 ^ 16'h0040, "abandoned after first cycle");
    seq(8'h90);
    repeat (2) @(negedge ref_clk);
    chk({7'b0, id_mode}, 8'h01, "id mode entered");
    rd(16'hF000, r);
    chk(r, VEND, "vendor code");
    rd(16'hF001, r);
    chk(r, MACR, "macro code");
    rd(16'hF002, r);
    chk(r, 8'h03, "size code");
    rd(16'hFF7F, r);
    chk(r, 8'hFF, "protect status");
    u_fcs_cpu_model.wr(16'($urandom), 8'hF0);
    repeat (2) @(negedge ref_clk);
    chk({7'b0, id_mode}, 8'h00, "single exit");
    seq(8'h90);
    seq(8'hF0);
    repeat (2) @(negedge ref_clk);
    chk({7'b0, id_mode}, 8'h00, "sequence exit");
    prog(16'hD123, 8'($urandom) | 8'h01);
    prog(16'hE010, 8'($urandom) | 8'h01);
    mode = FCS_MODE_PARALLEL;
    erase(8'h30, {4'hD, 12'($urandom)});
    idle_chk(16'hD123, "parallel sector erase");
    mode = FCS_MODE_MCU;
    erase(8'h30, {4'hD, 12'($urandom)});
    mem.delete(16'hD123);
    poll(16'hD123);
    rd(16'hE010, r);
    chk(r, expv(16'hE010), "other sector kept");
    seq(8'hA5);
    u_fcs_cpu_model.wr(16'hFF7F, 8'h00);
    poll(a1);
    chk({7'b0, rprot}, 8'h01, "protected");
    mode = FCS_MODE_SERIAL;
    repeat (3) @(negedge ref_clk);
    chk({7'b0, sblk}, 8'h01, "serial commands blocked");
    mode = FCS_MODE_PARALLEL;
    rd(16'hE010, r);
    chk(r, 8'h00, "parallel read blocked");
    mode = FCS_MODE_MCU;
    seq(8'h90);
    rd(16'hFF7F, r);
    chk({7'b0, r !== 8'hFF}, 8'h01, "protect status set");
    u_fcs_cpu_model.wr(16'h0000, 8'hF0);
    prog(a1 ^ 16'h0080, 8'h01);
    chk({7'b0, rprot}, 8'h01, "protect kept");
    mem.delete();
    erase(8'h10, 16'h0555);
    poll(a1);
    chk({7'b0, rprot}, 8'h00, "protect cleared by chip erase");
    end_sim();
  end
endmodule
